// ---- hw/rcg_regs.svh ----
// Register offsets, field positions and reset values of the run-mode clock gating block.
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH

`define RCG_OFF_CAP4 12'h01C
`define RCG_OFF_RUN_CFG 12'h060
`define RCG_OFF_RUN_GATE 12'h100
`define RCG_OFF_SLEEP_GATE 12'h110
`define RCG_OFF_DEEP_GATE 12'h120
`define RCG_OFF_IRQ_STAT 12'h180
`define RCG_OFF_IRQ_MASK 12'h184

`define RCG_BIT_WDT 3
`define RCG_BIT_HIB 6
`define RCG_SPD_LSB 8
`define RCG_SPD_MSB 11
`define RCG_BIT_ACG 27

`define RCG_GATE_WMASK 32'h00000F48
`define RCG_GATE_RESET 32'h00000000
`define RCG_CFG_WMASK 32'h08000000
`define RCG_CFG_RESET 32'h00000000
`define RCG_CAP4_VALUE 32'h5000007F
`define RCG_SPD_MAX 4'h2
`define RCG_SPD_ZERO 4'h0

`define RCG_IRQ_W 2
`define RCG_IRQ_FAULT 0
`define RCG_IRQ_CLAMP 1
`define RCG_IRQ_WMASK 32'h00000003
`define RCG_IRQ_ZERO 2'h0

`define RCG_ZERO32 32'h00000000

`endif

// ---- hw/rcg_pkg.sv ----
// Types shared by the run-mode clock gating block.
package rcg_pkg;

    typedef enum logic [1:0] {
        RCG_MODE_RUN = 2'b00,
        RCG_MODE_SLEEP = 2'b01,
        RCG_MODE_DEEP = 2'b10
    } rcg_mode_e;

    typedef logic [31:0] rcg_word_t;
    typedef logic [3:0] rcg_speed_t;

endpackage

// ---- hw/rcg_top.sv ----
// Run-mode clock gating registers, gating enables, bus fault on gated units and capability word.
`timescale 1ns/100ps
`include "rcg_regs.svh"

// Operation
// - Writable gating bits 3 and 6 each enable one unit clock.
// - Access to gated-off unit gives bus fault.
// - Gating bits reset to zero, units unclocked.
// - Speed field bits 11:8 select sample rate.
// - Bit 6 gates the low-power keeper clock.
// - Bit 3 gates watchdog; gated access faults.
// - Run, sleep, deep-sleep gating registers kept.
// - Sleep registers apply only with auto gating.
// - Reserved bits read zero, writes ignored.
// - Capability bits 0-6 report ports A-G present.
// - Capability bit 28 reports ethernet MAC present.
module rcg_top #(
    parameter int ADDR_W = 12,
    parameter rcg_pkg::rcg_speed_t SPD_MAX = `RCG_SPD_MAX
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire rcg_pkg::rcg_word_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output rcg_pkg::rcg_word_t reg_rdata_o,
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic wdt_access_i,
    input wire logic hib_access_i,
    output logic wdt_access_ok_o,
    output logic hib_access_ok_o,
    output logic bus_fault_o,
    output logic watchdog_clock_gate_o,
    output logic low_power_keeper_clock_gate_o,
    output rcg_pkg::rcg_speed_t converter_sample_speed_o,
    output rcg_pkg::rcg_mode_e power_mode_o,
    output logic irq_o
);
    import rcg_pkg::*;

    rcg_word_t run_clock_gating_0_ff;
    rcg_word_t sleep_clock_gating_0_ff;
    rcg_word_t deep_sleep_clock_gating_0_ff;
    rcg_word_t run_clock_configuration_ff;
    logic [`RCG_IRQ_W-1:0] irq_stat_ff;
    logic [`RCG_IRQ_W-1:0] irq_mask_ff;
    rcg_word_t rdata_ff;
    rcg_mode_e mode_ff;
    rcg_mode_e nxt_mode;
    logic wdt_en_ff;
    logic hib_en_ff;
    rcg_speed_t speed_ff;
    logic fault_ff;

    // Limits a written speed code to the device maximum.
    function automatic rcg_speed_t clamp_speed(input rcg_word_t w);
        rcg_speed_t s;
        s = w[`RCG_SPD_MSB:`RCG_SPD_LSB];
        clamp_speed = (s > SPD_MAX) ? SPD_MAX : s;
    endfunction

    // Builds the stored value of a gating register from a write.
    function automatic rcg_word_t gate_value(input rcg_word_t w);
        rcg_word_t v;
        v = w & `RCG_GATE_WMASK;
        v[`RCG_SPD_MSB:`RCG_SPD_LSB] = clamp_speed(w);
        gate_value = v;
    endfunction

    wire hit_run = (reg_addr_i == ADDR_W'(`RCG_OFF_RUN_GATE));
    wire hit_sleep = (reg_addr_i == ADDR_W'(`RCG_OFF_SLEEP_GATE));
    wire hit_deep = (reg_addr_i == ADDR_W'(`RCG_OFF_DEEP_GATE));
    wire hit_cfg = (reg_addr_i == ADDR_W'(`RCG_OFF_RUN_CFG));
    wire hit_cap = (reg_addr_i == ADDR_W'(`RCG_OFF_CAP4));
    wire hit_stat = (reg_addr_i == ADDR_W'(`RCG_OFF_IRQ_STAT));
    wire hit_mask = (reg_addr_i == ADDR_W'(`RCG_OFF_IRQ_MASK));

    wire wr_gate = reg_wr_i && (hit_run || hit_sleep || hit_deep);
    // A code above the limit is stored as the limit, and the clamp is reported.
    wire clamp_evt = wr_gate && (reg_wdata_i[`RCG_SPD_MSB:`RCG_SPD_LSB] > SPD_MAX);
    wire acg_on = run_clock_configuration_ff[`RCG_BIT_ACG];

    // The mode follows the power request; deep sleep outranks sleep.
    always_comb begin
        if (deep_sleep_req_i) begin
            nxt_mode = RCG_MODE_DEEP;
        end else if (sleep_req_i) begin
            nxt_mode = RCG_MODE_SLEEP;
        end else begin
            nxt_mode = RCG_MODE_RUN;
        end
    end

    // Sleep copies only count when auto gating is on; otherwise run values stay.
    rcg_word_t active_gate;
    always_comb begin
        case (mode_ff)
            RCG_MODE_RUN: active_gate = run_clock_gating_0_ff;
            RCG_MODE_SLEEP: active_gate = acg_on ? sleep_clock_gating_0_ff
                : run_clock_gating_0_ff;
            RCG_MODE_DEEP: active_gate = acg_on ? deep_sleep_clock_gating_0_ff
                : run_clock_gating_0_ff;
            default: active_gate = run_clock_gating_0_ff;
        endcase
    end

    wire fault_evt = (wdt_access_i && !wdt_en_ff) || (hib_access_i && !hib_en_ff);
    wire [`RCG_IRQ_W-1:0] irq_set = {clamp_evt, fault_evt};
    wire [`RCG_IRQ_W-1:0] irq_clr = (reg_wr_i && hit_stat) ?
        reg_wdata_i[`RCG_IRQ_W-1:0] : `RCG_IRQ_ZERO;

    rcg_word_t rd_mux;
    assign rd_mux = hit_run ? run_clock_gating_0_ff :
        hit_sleep ? sleep_clock_gating_0_ff :
        hit_deep ? deep_sleep_clock_gating_0_ff :
        hit_cfg ? run_clock_configuration_ff :
        hit_cap ? `RCG_CAP4_VALUE :
        hit_stat ? rcg_word_t'(irq_stat_ff) :
        hit_mask ? rcg_word_t'(irq_mask_ff) :
        `RCG_ZERO32;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            run_clock_gating_0_ff <= `RCG_GATE_RESET;
            sleep_clock_gating_0_ff <= `RCG_GATE_RESET;
            deep_sleep_clock_gating_0_ff <= `RCG_GATE_RESET;
        end else begin
            if (reg_wr_i && hit_run) begin
                run_clock_gating_0_ff <= gate_value(reg_wdata_i);
            end
            if (reg_wr_i && hit_sleep) begin
                sleep_clock_gating_0_ff <= gate_value(reg_wdata_i);
            end
            if (reg_wr_i && hit_deep) begin
                deep_sleep_clock_gating_0_ff <= gate_value(reg_wdata_i);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            run_clock_configuration_ff <= `RCG_CFG_RESET;
            irq_mask_ff <= `RCG_IRQ_ZERO;
        end else begin
            if (reg_wr_i && hit_cfg) begin
                run_clock_configuration_ff <= reg_wdata_i & `RCG_CFG_WMASK;
            end
            if (reg_wr_i && hit_mask) begin
                irq_mask_ff <= reg_wdata_i[`RCG_IRQ_W-1:0];
            end
        end
    end

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irq_stat_ff <= `RCG_IRQ_ZERO;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rdata_ff <= `RCG_ZERO32;
        end else begin
            rdata_ff <= reg_rd_i ? rd_mux : `RCG_ZERO32;
        end
    end

    // Enables come straight from flops so a gate cell never sees a combinational glitch.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode_ff <= RCG_MODE_RUN;
            wdt_en_ff <= 1'b0;
            hib_en_ff <= 1'b0;
            speed_ff <= `RCG_SPD_ZERO;
            fault_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            wdt_en_ff <= active_gate[`RCG_BIT_WDT];
            hib_en_ff <= active_gate[`RCG_BIT_HIB];
            speed_ff <= active_gate[`RCG_SPD_MSB:`RCG_SPD_LSB];
            fault_ff <= fault_evt;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign watchdog_clock_gate_o = wdt_en_ff;
    assign low_power_keeper_clock_gate_o = hib_en_ff;
    assign converter_sample_speed_o = speed_ff;
    assign power_mode_o = mode_ff;
    assign bus_fault_o = fault_ff;
    assign wdt_access_ok_o = wdt_access_i && wdt_en_ff;
    assign hib_access_ok_o = hib_access_i && hib_en_ff;
    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // Checks.
    sequence s_run_wdt_write;
        reg_wr_i && hit_run && mode_ff == RCG_MODE_RUN && nxt_mode == RCG_MODE_RUN;
    endsequence

    sequence s_stay_run;
        mode_ff == RCG_MODE_RUN;
    endsequence

    a_write_to_enable: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_run_wdt_write ##1 s_stay_run |=>
            watchdog_clock_gate_o == $past(reg_wdata_i[`RCG_BIT_WDT], 2))
        else $error("Watchdog enable did not follow the run gating write.");

    a_wdt_gate_follow: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !$past(reset_i) |-> watchdog_clock_gate_o == $past(active_gate[`RCG_BIT_WDT]))
        else $error("Watchdog enable differs from the active gating bit.");

    a_hib_gate_follow: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !$past(reset_i) |->
            low_power_keeper_clock_gate_o == $past(active_gate[`RCG_BIT_HIB]))
        else $error("Keeper enable differs from the active gating bit.");

    a_gated_fault: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (wdt_access_i && !watchdog_clock_gate_o) ||
            (hib_access_i && !low_power_keeper_clock_gate_o) |=> bus_fault_o)
        else $error("Access to a gated unit gave no bus fault.");

    a_clocked_no_fault: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !(wdt_access_i && !watchdog_clock_gate_o) &&
            !(hib_access_i && !low_power_keeper_clock_gate_o) |=> !bus_fault_o)
        else $error("Bus fault without an access to a gated unit.");

    a_reset_zero: assert property (
        @(posedge clk_sys_i)
        reset_i |=> run_clock_gating_0_ff == `RCG_GATE_RESET &&
            !watchdog_clock_gate_o && !low_power_keeper_clock_gate_o &&
            converter_sample_speed_o == `RCG_SPD_ZERO)
        else $error("Gating state not cleared by reset.");

    a_speed_limit: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        converter_sample_speed_o <= SPD_MAX)
        else $error("Sample speed code above the device maximum.");

    a_clamp_flag: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        clamp_evt |=> irq_stat_ff[`RCG_IRQ_CLAMP])
        else $error("Clamped speed write not flagged in status.");

    a_hib_write_enable: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_run_wdt_write ##1 s_stay_run |=>
            low_power_keeper_clock_gate_o == $past(reg_wdata_i[`RCG_BIT_HIB], 2))
        else $error("Keeper enable did not follow the run gating write.");

    // A fault in the same cycle as its clear must still be seen by software.
    a_fault_sticky: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        fault_evt |=> irq_stat_ff[`RCG_IRQ_FAULT])
        else $error("Gated access did not set the fault status bit.");

    a_deep_outranks: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        deep_sleep_req_i |=> power_mode_o == RCG_MODE_DEEP)
        else $error("Deep-sleep request did not select deep-sleep mode.");

    a_cfg_reserved: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_rd_i && hit_cfg |=> (reg_rdata_o & ~`RCG_CFG_WMASK) == `RCG_ZERO32)
        else $error("Reserved configuration bits read nonzero.");

    a_sleep_select: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        mode_ff == RCG_MODE_SLEEP |-> active_gate ==
            (acg_on ? sleep_clock_gating_0_ff : run_clock_gating_0_ff))
        else $error("Wrong gating register applied in sleep.");

    a_deep_select: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        mode_ff == RCG_MODE_DEEP |-> active_gate ==
            (acg_on ? deep_sleep_clock_gating_0_ff : run_clock_gating_0_ff))
        else $error("Wrong gating register applied in deep sleep.");

    a_reserved_zero: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_rd_i && (hit_run || hit_sleep || hit_deep) |=>
            (reg_rdata_o & ~`RCG_GATE_WMASK) == `RCG_ZERO32)
        else $error("Reserved gating bits read nonzero.");

    a_cap_value: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        reg_rd_i && hit_cap |=> reg_rdata_o == `RCG_CAP4_VALUE)
        else $error("Capability word read wrong.");

    a_irq_level: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        irq_o == |(irq_stat_ff & irq_mask_ff))
        else $error("Interrupt output does not match status and mask.");

endmodule // rcg_top

// ---- verification/tb.sv ----
// Self-checking testbench for the run-mode clock gating block.
`timescale 1ns/100ps
`include "rcg_regs.svh"
module tb;
    import rcg_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    rcg_word_t reg_wdata_i = 32'h00000000, reg_rdata_o, rd_val;
    logic sleep_req_i = 1'b0, deep_sleep_req_i = 1'b0, wdt_access_i = 1'b0, hib_access_i = 1'b0;
    logic wdt_access_ok_o, hib_access_ok_o, bus_fault_o, irq_o;
    logic watchdog_clock_gate_o, low_power_keeper_clock_gate_o;
    rcg_speed_t converter_sample_speed_o;
    rcg_mode_e power_mode_o;
    int errors = 0, comparisons = 0;
    rcg_top rcg_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sleep_req_i(sleep_req_i), .deep_sleep_req_i(deep_sleep_req_i),
        .wdt_access_i(wdt_access_i), .hib_access_i(hib_access_i),
        .wdt_access_ok_o(wdt_access_ok_o), .hib_access_ok_o(hib_access_ok_o),
        .bus_fault_o(bus_fault_o), .watchdog_clock_gate_o(watchdog_clock_gate_o),
        .low_power_keeper_clock_gate_o(low_power_keeper_clock_gate_o),
        .converter_sample_speed_o(converter_sample_speed_o), .power_mode_o(power_mode_o),
        .irq_o(irq_o));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 rd_val = reg_rdata_o;
    endtask
    // Enables and status are registered, so outputs are judged two edges after the cause.
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic t_reset();
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o, irq_o, bus_fault_o}, 4'h0);
        rd(`RCG_OFF_RUN_GATE);
        chk(rd_val, 32'h00000000);
        rd(`RCG_OFF_CAP4);
        chk(rd_val[6:0], 32'h0000007F);
        chk({rd_val[29:28], rd_val[27:7]}, 32'h00200000);
        wr(`RCG_OFF_CAP4, 32'h00000000);
        rd(`RCG_OFF_CAP4);
        chk(rd_val, 32'h5000007F);
        rd(12'h3FC);
        chk(rd_val, 32'h00000000);
    endtask
    task automatic t_bits();
        // All ones: reserved bits drop and the oversized speed code is held at the limit.
        wr(`RCG_OFF_RUN_GATE, 32'hFFFFFFFF);
        rd(`RCG_OFF_RUN_GATE);
        chk(rd_val, 32'h00000248);
        settle();
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h3);
        chk(converter_sample_speed_o, 4'h2);
        wr(`RCG_OFF_RUN_GATE, 32'h00000040);
        settle();
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h1);
        for (int c = 0; c < 3; c++) begin
            wr(`RCG_OFF_RUN_GATE, 32'(c) << 8);
            rd(`RCG_OFF_RUN_GATE);
            chk(rd_val, 32'(c) << 8);
            chk(converter_sample_speed_o, 4'(c));
        end
        rd(`RCG_OFF_IRQ_STAT);
        chk(rd_val[1:0], 2'h2);
        wr(`RCG_OFF_IRQ_STAT, 32'h00000002);
    endtask
    task automatic t_fault();
        wr(`RCG_OFF_RUN_GATE, 32'h00000040);
        settle();
        @(posedge clk_sys_i);
        wdt_access_i <= 1'b1;
        hib_access_i <= 1'b1;
        #1 chk({wdt_access_ok_o, hib_access_ok_o}, 2'h1);
        @(posedge clk_sys_i);
        wdt_access_i <= 1'b0;
        hib_access_i <= 1'b0;
        #1 chk(bus_fault_o, 1'b1);
        @(posedge clk_sys_i);
        #1 chk(bus_fault_o, 1'b0);
        chk(irq_o, 1'b0);
        wr(`RCG_OFF_IRQ_MASK, 32'h00000001);
        settle();
        chk(irq_o, 1'b1);
        wr(`RCG_OFF_IRQ_STAT, 32'h00000001);
        settle();
        chk(irq_o, 1'b0);
        wr(`RCG_OFF_RUN_GATE, 32'h00000008);
        settle();
        @(posedge clk_sys_i);
        wdt_access_i <= 1'b1;
        #1 chk(wdt_access_ok_o, 1'b1);
        @(posedge clk_sys_i);
        wdt_access_i <= 1'b0;
        #1 chk(bus_fault_o, 1'b0);
        @(posedge clk_sys_i);
        hib_access_i <= 1'b1;
        #1 chk(hib_access_ok_o, 1'b0);
        @(posedge clk_sys_i);
        hib_access_i <= 1'b0;
        #1 chk(bus_fault_o, 1'b1);
    endtask
    task automatic t_modes();
        wr(`RCG_OFF_SLEEP_GATE, 32'h00000040);
        wr(`RCG_OFF_DEEP_GATE, 32'h00000048);
        rd(`RCG_OFF_SLEEP_GATE);
        chk(rd_val, 32'h00000040);
        rd(`RCG_OFF_DEEP_GATE);
        chk(rd_val, 32'h00000048);
        @(posedge clk_sys_i);
        sleep_req_i <= 1'b1;
        settle();
        chk(power_mode_o, RCG_MODE_SLEEP);
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h2);
        wr(`RCG_OFF_RUN_CFG, 32'hFFFFFFFF);
        rd(`RCG_OFF_RUN_CFG);
        chk(rd_val, 32'h08000000);
        settle();
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h1);
        @(posedge clk_sys_i);
        deep_sleep_req_i <= 1'b1;
        settle();
        chk(power_mode_o, RCG_MODE_DEEP);
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h3);
        @(posedge clk_sys_i);
        sleep_req_i <= 1'b0;
        deep_sleep_req_i <= 1'b0;
        settle();
        chk(power_mode_o, RCG_MODE_RUN);
        chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o}, 2'h2);
    endtask
    // A reset in mid-run must drop every enable, even ones software had turned on.
    task automatic t_rereset();
        wr(`RCG_OFF_RUN_GATE, 32'h00000248);
        wr(`RCG_OFF_IRQ_MASK, 32'h00000003);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        #1 chk(watchdog_clock_gate_o, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1 chk({watchdog_clock_gate_o, low_power_keeper_clock_gate_o, irq_o,
            converter_sample_speed_o}, 32'h00000000);
        rd(`RCG_OFF_RUN_GATE);
        chk(rd_val, 32'h00000000);
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        // The whole sequence takes well under a thousand cycles.
        #200000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_bits();
        t_fault();
        t_modes();
        t_rereset();
        report_and_stop();
    end
endmodule // tb
